// file: hdl/sbs_sram.sv
`timescale 1ns/100ps
`include "sbs_defines.svh"
module sbs_sram
    import sbs_pkg::*;
#(
    parameter int ADDR_W = `SBS_ADDR_W,
    parameter int WORDS = `SBS_WORDS
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic primary_chip_enable_n_in,
    input wire logic secondary_chip_enables_n_in,
    input wire logic secondary_chip_enables_in,
    input wire logic processor_address_strobe_n_in,
    input wire logic controller_address_strobe_n_in,
    input wire logic burst_advance_n_in,
    input wire logic byte_write_enable_lane1_n_in,
    input wire logic byte_write_enable_lane2_n_in,
    input wire logic byte_write_enable_lane3_n_in,
    input wire logic byte_write_enable_lane4_n_in,
    input wire logic output_enable_n_in,
    input wire logic parity_lane_disable_in,
    input wire logic [`SBS_DATA_W-1:0] data_lines_in,
    input wire logic [`SBS_LANES-1:0] parity_lines_in,
    output logic [`SBS_DATA_W-1:0] data_lines_out,
    output logic [`SBS_DATA_W-1:0] data_lines_oe_out,
    output logic [`SBS_LANES-1:0] parity_lines_out,
    output logic [`SBS_LANES-1:0] parity_lines_oe_out,
    output logic deselected_out
);

    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    // Inputs come from the controller on this same clock, so no
    // synchroniser stages are placed in front of them.
    sbs_state_t st_reg, st_next;
    logic [`SBS_LANES-1:0] bwe_n;
    logic [`SBS_DATA_W-1:0] data_lines_out_c;
    logic [`SBS_LANES-1:0] parity_c;
    logic des_reg, des_next;
    logic enables_on, load_p, load_c, deselect, is_write, step;
    logic [1:0] low_addr;
    logic [ADDR_W-1:0] word_addr;

    // Lane write enables gathered low lane first.
    // byte lane order
    assign bwe_n = {byte_write_enable_lane4_n_in, byte_write_enable_lane3_n_in,
        byte_write_enable_lane2_n_in, byte_write_enable_lane1_n_in};

    // Write decision is shared by controller loads and continue cycles; a processor load is always a read.
    function automatic logic any_write(input logic [`SBS_LANES-1:0] b);
        any_write = ~&b;
    endfunction : any_write

    // ------------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------------
    // Enables are looked at only in the load and deselect terms below, which all need a strobe,
    // so continue and suspend cycles never see them.
    always_comb begin
        enables_on = ~primary_chip_enable_n_in &
            ~secondary_chip_enables_n_in & secondary_chip_enables_in;
        deselect = (~controller_address_strobe_n_in & primary_chip_enable_n_in)
            | ((~processor_address_strobe_n_in
            | ~controller_address_strobe_n_in)
            & ~primary_chip_enable_n_in & ~enables_on);
        load_p = ~processor_address_strobe_n_in & enables_on;
        load_c = processor_address_strobe_n_in &
            ~controller_address_strobe_n_in & enables_on;
        is_write = any_write(bwe_n);
        step = ~burst_advance_n_in;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        des_next = des_reg;
        st_next.drive = 1'b0;
        if (deselect) begin
            st_next.cycle = SBS_IDLE;
            st_next.active = 1'b0;
            des_next = 1'b1;
        end else if (load_p) begin
            st_next.upper = address_in[ADDR_W-1:2];
            st_next.start_low = address_in[1:0];
            st_next.beat = 2'h0;
            st_next.active = 1'b1;
            st_next.cycle = SBS_READ;
            des_next = 1'b0;
        end else if (load_c) begin
            st_next.upper = address_in[ADDR_W-1:2];
            st_next.start_low = address_in[1:0];
            st_next.beat = 2'h0;
            st_next.active = 1'b1;
            st_next.cycle = is_write ? SBS_WRITE : SBS_READ;
            des_next = 1'b0;
        end else if (st_reg.active) begin
            if (step) begin
                st_next.beat = st_reg.beat + 2'h1;
            end
            st_next.cycle = is_write ? SBS_WRITE : SBS_READ;
        end else begin
            st_next.cycle = SBS_IDLE;
        end
        if (st_next.cycle == SBS_READ) begin
            st_next.drive = 1'b1;
            st_next.rdata = '0;
        end
    end

    // ------------------------------------------------------------------
    // Address generation
    // ------------------------------------------------------------------
    // interleaved order
    assign low_addr = st_next.start_low ^ st_next.beat;
    assign word_addr = {st_next.upper, low_addr};

    // ------------------------------------------------------------------
    // Array lanes
    // ------------------------------------------------------------------
    // Each lane keeps its byte plus parity bit so a partial write never
    // disturbs its neighbours.
    for (genvar l = 0; l < `SBS_LANES; l++) begin : g_lane
        // One lane of the array: eight data bits with the parity bit on top.
        // Each lane owns its storage, so only one process ever writes it.
        logic [`SBS_LANE_W:0] mem [WORDS];
        logic [`SBS_LANE_W:0] rd_reg;
        logic wr;
        assign wr = (st_next.cycle == SBS_WRITE) & ~bwe_n[l];
        always_ff @(posedge sys_clk_in) begin
            if (wr) begin
                mem[word_addr] <= {parity_lane_disable_in ?
                    mem[word_addr][`SBS_LANE_W] : parity_lines_in[l],
                    data_lines_in[l*`SBS_LANE_W +: `SBS_LANE_W]};
            end
            rd_reg <= mem[word_addr];
        end
        assign data_lines_out_c[l*`SBS_LANE_W +: `SBS_LANE_W] =
            rd_reg[`SBS_LANE_W-1:0];
        assign parity_c[l] = rd_reg[`SBS_LANE_W];
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Every synchronous input is taken at the rising edge only; the
    // output enable and parity lane disable gate the drivers without the clock, and reset acts at once.
    // rising edge sampling
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= '{cycle: SBS_IDLE, default: '0};
            des_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            des_reg <= des_next;
        end
    end

    // ------------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------------
    // Output enable is asynchronous on the pin; here it is combined with
    // the registered read flag, which costs one gate after the flop.
    always_comb begin
        data_lines_out = data_lines_out_c;
        parity_lines_out = parity_c;
        data_lines_oe_out = {`SBS_DATA_W{st_reg.drive & ~output_enable_n_in}};
        parity_lines_oe_out = {`SBS_LANES{st_reg.drive &
            ~output_enable_n_in & ~parity_lane_disable_in}};
        deselected_out = des_reg;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // A new address is taken by either strobe with every enable active.
    sequence s_addr_load;
        load_p || load_c;
    endsequence

    // A live burst steps: no strobe takes effect and advance is low.
    sequence s_burst_step;
        st_reg.active && !deselect && !load_p && !load_c && step;
    endsequence

    // Wait state with a write, as the controller drives it after a
    // processor load so that the write lands on the loaded address.
    sequence s_write_hold;
        processor_address_strobe_n_in && controller_address_strobe_n_in
            && burst_advance_n_in && is_write;
    endsequence

    // A deselect drops the burst and releases the bus next cycle.
    chk_deselect_release: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) deselect |=> !st_reg.drive && des_reg)
        else $error("deselect did not release bus");

    // A processor strobe load is always a read, whatever the lane enables.
    chk_load_read: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) load_p |=> st_reg.cycle == SBS_READ)
        else $error("processor load not a read");

    // A controller strobe load with a lane enable low starts a write.
    chk_ctrl_write: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) load_c && is_write |=> st_reg.cycle == SBS_WRITE)
        else $error("controller write load missed");

    // Stepping moves the beat by one; the two bits wrap by themselves.
    chk_wrap_count: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) st_reg.active && !deselect && !load_p
        && !load_c && step |=> st_reg.beat == $past(st_reg.beat) + 2'h1)
        else $error("burst count wrong");

    // A wait state leaves the beat where it was.
    chk_suspend_hold: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) st_reg.active && !deselect && !load_p
        && !load_c && !step |=> $stable(st_reg.beat))
        else $error("suspend moved counter");

    // With parity disabled the parity lines never drive.
    chk_parity_off: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) parity_lane_disable_in |-> parity_lines_oe_out == 0)
        else $error("parity driven while disabled");

    // Output enable high keeps every data line released.
    chk_oe_gate: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) output_enable_n_in |-> data_lines_oe_out == 0)
        else $error("data driven with oe high");

    // A write cycle never turns the data drivers on.
    chk_write_no_drive: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) st_reg.cycle == SBS_WRITE |-> !st_reg.drive)
        else $error("bus driven in write");

    // Nothing drives on the first edge after reset is released.
    chk_reset_quiet: assert property (@(posedge sys_clk_in)
        $fell(rst_in) |-> data_lines_oe_out == 0)
        else $error("bus driven at reset release");

    // The registered address and a zero beat come from the load edge.
    chk_load_address: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        s_addr_load |=> st_reg.upper == $past(address_in[ADDR_W-1:2])
        && st_reg.start_low == $past(address_in[1:0]) && st_reg.beat == 2'h0)
        else $error("loaded address not registered");

    // Four steps after a load bring the beat back to the start.
    chk_burst_wrap: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        s_addr_load ##1 s_burst_step [*4] |=> st_reg.beat == 2'h0)
        else $error("burst did not wrap to start");

    // A write held after a processor load stays on the loaded beat.
    chk_proc_write: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        load_p ##1 s_write_hold |=> st_reg.cycle == SBS_WRITE
        && $stable(st_reg.beat))
        else $error("write after processor load misplaced");

    // A continue or wait state with any lane enable low is a write.
    chk_continue_write: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        st_reg.active && !deselect && !load_p && !load_c && is_write
        |=> st_reg.cycle == SBS_WRITE)
        else $error("continued write not taken");

    // A read with output enable low drives every data line.
    chk_read_drive: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        st_reg.cycle == SBS_READ && !output_enable_n_in
        |-> &data_lines_oe_out)
        else $error("read data not driven");

    // Without a strobe the enables may change and the burst goes on.
    chk_enables_ignored: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        st_reg.active && processor_address_strobe_n_in
        && controller_address_strobe_n_in
        |=> st_reg.active && $stable(st_reg.upper))
        else $error("enables broke a running burst");

    // The power-down flag is exactly the absence of a burst.
    chk_select_flag: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        st_reg.active == !deselected_out)
        else $error("deselect flag disagrees with burst");

    // A deselect leaves the block idle on the following cycle.
    chk_deselect_idle: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        deselect |=> st_reg.cycle == SBS_IDLE && !st_reg.active)
        else $error("deselect left a cycle running");

    // With no burst the data and parity lines stay released.
    chk_idle_quiet: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        !st_reg.active |-> data_lines_oe_out == 0 && parity_lines_oe_out == 0)
        else $error("bus driven while idle");

    // With parity enabled the parity lines drive like the data lines.
    chk_parity_follow: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        !parity_lane_disable_in
        |-> parity_lines_oe_out == {`SBS_LANES{data_lines_oe_out[0]}})
        else $error("parity drive differs from data");

endmodule : sbs_sram

// file: hdl/sbs_defines.svh
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH
`define SBS_ADDR_W 15
`define SBS_LANES 4
`define SBS_LANE_W 8
`define SBS_DATA_W 32
`define SBS_WORDS 32768
`define SBS_BURST_LEN 4
`endif

// file: hdl/sbs_pkg.sv
`include "sbs_defines.svh"
package sbs_pkg;
    typedef enum logic [2:0] {
        SBS_IDLE = 3'b001,
        SBS_READ = 3'b010,
        SBS_WRITE = 3'b100
    } sbs_cycle_t;
    typedef struct packed {
        logic [`SBS_DATA_W-1:0] data;
        logic [`SBS_LANES-1:0] parity;
    } sbs_word_t;
    typedef struct packed {
        sbs_cycle_t cycle;
        logic active;
        logic [`SBS_ADDR_W-1:2] upper;
        logic [1:0] start_low;
        logic [1:0] beat;
        logic drive;
        sbs_word_t rdata;
    } sbs_state_t;
endpackage : sbs_pkg

// file: verif/sbs_ctl_model.sv
`timescale 1ns/100ps
// Cache controller model: it launches one bus cycle per call of run_cycle.
module sbs_ctl_model (
    input wire logic clk_in,
    output logic [14:0] addr_out,
    output logic [2:0] ce_out,
    output logic [2:0] st_out,
    output logic [3:0] bw_n_out,
    output logic oe_n_out,
    output logic parity_lane_disable_out,
    output logic [35:0] wd_out
);
    // The bus idles with the strobes high and the enables active.
    initial begin
        {addr_out, ce_out, st_out, bw_n_out, oe_n_out, parity_lane_disable_out} = 27'h3FC;
        wd_out = 36'h0;
    end
    task automatic run_cycle(input logic [2:0] ce, st, input logic [3:0] bw,
            input logic [14:0] a, input logic [35:0] d, input logic oe, pd);
        @(negedge clk_in);
        {ce_out, bw_n_out, parity_lane_disable_out} = {ce, bw, pd};
        st_out = {st[2:1], st[0] | (!st_out[2] && !(&bw))};
        oe_n_out = (&bw) ? oe : 1'b1;
        addr_out = (&st[2:1]) ? ~addr_out : a; // Unused lines flip.
        wd_out = (&bw) ? ~wd_out : d;
        @(posedge clk_in);
    endtask : run_cycle
endmodule : sbs_ctl_model

// file: verif/sync_burst_sram_control_tb_top.sv
`timescale 1ns/100ps
module sync_burst_sram_control_tb_top;
    logic clk, rst, oe_n, parity_lane_disable, desel, act;
    logic [14:0] addr, cur, b;
    logic [2:0] ce, st;
    logic [3:0] bw_n, p_q, p_oe;
    logic [31:0] d_q, d_oe;
    logic [35:0] wd;
    logic [1:0] bi;
    logic [35:0] mem [logic [14:0]];
    int seed = 39322, fail_count = 0, cmp_count = 0;
    sbs_ctl_model u_ctl (.clk_in(clk), .addr_out(addr), .ce_out(ce),
        .st_out(st), .bw_n_out(bw_n), .oe_n_out(oe_n), .parity_lane_disable_out(parity_lane_disable),
        .wd_out(wd));
    sbs_sram u_dut (.sys_clk_in(clk), .rst_in(rst), .address_in(addr),
        .primary_chip_enable_n_in(ce[2]), .secondary_chip_enables_n_in(ce[1]),
        .secondary_chip_enables_in(ce[0]), .output_enable_n_in(oe_n),
        .processor_address_strobe_n_in(st[2]), .burst_advance_n_in(st[0]),
        .controller_address_strobe_n_in(st[1]), .data_lines_in(wd[35:4]),
        .byte_write_enable_lane1_n_in(bw_n[0]), .parity_lines_in(wd[3:0]),
        .byte_write_enable_lane2_n_in(bw_n[1]), .data_lines_out(d_q),
        .byte_write_enable_lane3_n_in(bw_n[2]), .parity_lines_out(p_q),
        .byte_write_enable_lane4_n_in(bw_n[3]), .deselected_out(desel),
        .parity_lane_disable_in(parity_lane_disable), .data_lines_oe_out(d_oe),
        .parity_lines_oe_out(p_oe));
    // The clock is toggled every half period of 2.5 ns.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [35:0] e, g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    function automatic logic [35:0] merge(input logic [35:0] o, n,
            input logic [3:0] bw, input logic pd);
        logic [35:0] m;
        m = {{8{!bw[3]}}, {8{!bw[2]}}, {8{!bw[1]}}, {8{!bw[0]}},
            ~bw & {4{!pd}}};
        return (o & ~m) | (n & m);
    endfunction : merge
    task automatic cyc(input logic [2:0] c, s, input logic [3:0] bw,
            input logic [14:0] a, input logic o, pd);
        logic ld, dr;
        logic [14:0] ea;
        u_ctl.run_cycle(c, s, bw, a, {$random(seed), 4'(seed)}, o, pd);
        #1;
        ld = (!st[2] && !ce[2]) || !st[1];
        {act, cur, bi} = ld ? {ce == 3'h1, addr, 2'h0} :
            {act, cur, bi + 2'(!st[0])};
        ea = {cur[14:2], cur[1:0] ^ bi};
        dr = act && ((&bw_n) || (!st[2] && !ce[2])) && !oe_n;
        if (act && !(&bw_n) && (st[2] || ce[2])) begin
            mem[ea] = merge(mem.exists(ea) ? mem[ea] : 36'hX, wd, bw_n, parity_lane_disable);
        end
        chk("deselected", 36'(!act), 36'(desel));
        chk("drive", {{32{dr}}, {4{dr && !parity_lane_disable}}}, {d_oe, p_oe});
        if (dr) begin
            chk("read", mem[ea], {d_q, p_q});
        end
    endtask : cyc
    task automatic stop_test();
        $display("compares %0d errors %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    // The watchdog allows almost forty times the length of the sequence.
    initial begin
        #20000;
        fail_count++;
        stop_test();
    end
    // Reset, directed bursts and deselects, then a random mix in one group.
    initial begin
        {rst, act, cur, bi} = {2'b10, 15'h0000, 2'h0};
        b = 15'($random(seed));
        repeat (8) @(posedge clk);
        chk("reset drive", 36'h0, {d_oe, p_oe});
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 10; i++) begin
            cyc(3'h1, (i == 0 || i == 4) ? 3'h5 : (i == 7 ? 3'h7 : 3'h6),
                i < 4 ? 4'h0 : 4'($random(seed)), b, 1'b0, i == 9);
        end
        cyc(3'h1, 3'h3, 4'hF, b ^ 15'h0002, 1'b0, 1'b0);
        cyc(3'h1, 3'h6, 4'h0, b, 1'b0, 1'b0);
        cyc(3'h1, 3'h5, 4'hF, b ^ 15'h0002, 1'b0, 1'b0);
        for (int k = 0; k < 3; k++) begin
            cyc(k == 0 ? 3'h5 : (k == 1 ? 3'h0 : 3'h3),
                k == 0 ? 3'h1 : (k == 1 ? 3'h3 : 3'h5), 4'hF, b, 1'b0, 1'b0);
        end
        for (int i = 0; i < 80; i++) begin
            cyc(($random(seed) & 3) ? 3'h1 : 3'($random(seed)),
                3'($random(seed)), 4'($random(seed)), {b[14:2], 2'(i)},
                1'($random(seed)), 1'($random(seed)));
        end
        stop_test();
    end
endmodule : sync_burst_sram_control_tb_top
